// ### hdl/cie_core_exec.sv
// instruction execution datapath with apb register access
// Function
// - zero-skip writes byte back, skips when zero, no flags
// - copy-skip loads acc, skips when zero, no flags
// - bit-skip skips when selected bit is zero
// - taken skip adds one dummy cycle
// - paged read at high:low pointer, high byte latched
// - final-page read uses low pointer, last page
// - bump low pointer, then paged read
// - bump low pointer, then final-page read
// - full data address reaches any section
// - add with carry, five arithmetic flags
// - add without carry, same five flags
// - clear writes zero byte, no flags
// - bit clear forces selected bit low, no flags
// - complement byte, zero flag only
// - decimal adjust adds six per nibble, to byte
// - decimal adjust changes only carry
// - decrement byte, zero flag only
// - increment byte, zero flag only
// - move byte to acc or acc to byte, no flags
// - or to acc or byte, zero flag only
//
// Our own choices: the APB interface to the registers and the address map.
module cie_core_exec
   import cie_pkg::*;
#(
   parameter int AW = PA,                        // program address width
   parameter int MA = 16                         // data memory address width
)(
   input  wire logic          clk_in,            // core clock, 100 MHz
   input  wire logic          rst_in,            // sync reset, high
   input  wire logic          ce_in,             // clock enable
   // apb slave
   input  wire logic          psel_in,           // select
   input  wire logic          penable_in,        // access phase
   input  wire logic          pwrite_in,         // write
   input  wire logic [7:0]    paddr_in,          // byte address
   input  wire logic [31:0]   pwdata_in,         // write data
   output logic [31:0]        prdata_out,        // read data
   output logic               pready_out,        // transfer done
   output logic               pslverr_out,       // unmapped address
   // execute port
   input  wire logic          exec_valid_in,     // issue, one cycle
   input  wire cie_op_t       exec_op_in,        // operation
   input  wire logic [MA-1:0] exec_addr_in,      // full data address
   input  wire logic [DW-1:0] exec_mem_in,       // byte at that address
   input  wire logic [DW-1:0] exec_imm_in,       // immediate
   input  wire logic [2:0]    exec_bit_in,       // bit select
   output logic               busy_out,          // issue not taken
   output logic               done_out,          // instruction end
   output logic               skip_out,          // next one skipped
   // data memory write
   output logic               mem_we_out,        // write strobe
   output logic [MA-1:0]      mem_addr_out,      // write address
   output logic [DW-1:0]      mem_wdata_out,     // write data
   // program memory read
   output logic               pm_req_out,        // read request
   output logic [AW-1:0]      pm_addr_out,       // word address
   input  wire logic          pm_valid_in,       // word present
   input  wire logic [PW-1:0] pm_data_in,        // program word
   // core state
   output logic [DW-1:0]      acc_out,           // accumulator
   output logic [FL_W-1:0]    flags_out          // status flags
);

   // table operations leave for the program memory fetch
   function automatic logic is_table(input cie_op_t op);
      is_table = (op == OP_TAB_PAGED) || (op == OP_TAB_FINAL) ||
                 (op == OP_BTAB_PAGED) || (op == OP_BTAB_FINAL);
   endfunction : is_table

   function automatic logic is_bump(input cie_op_t op);
      is_bump = (op == OP_BTAB_PAGED) || (op == OP_BTAB_FINAL);
   endfunction : is_bump

   cie_state_t          state_r;
   cie_state_t          state_nxt;
   logic [DW-1:0]       acc_r;
   logic [FL_W-1:0]     flags_r;
   logic [31:0]         prdata_nxt;

   // alu outputs
   logic [DW-1:0]       alu_res;
   logic [FL_W-1:0]     alu_flags;
   logic                alu_wr_acc;
   logic                alu_wr_mem;
   logic                alu_skip;

   // table unit outputs
   logic [DW-1:0]       tp_lo;
   logic [AW-DW-1:0]    tp_hi;
   logic [DW-1:0]       tp_hlat;
   logic [AW-1:0]       tp_addr;

   // issue accepted only while idle; busy_out warns the issuer
   wire logic issue   = ce_in & exec_valid_in & (state_r == ST_IDLE);
   wire logic tab_go  = issue & is_table(exec_op_in);
   wire logic alu_go  = issue & !is_table(exec_op_in);
   wire logic word_in = ce_in & (state_r == ST_FETCH) & pm_valid_in;

   // apb decode: second access cycle completes the transfer
   wire logic apb_acc  = psel_in & penable_in & pready_out;
   wire logic apb_wr   = apb_acc & pwrite_in;
   wire logic hit_acc  = (paddr_in == RA_ACC);
   wire logic hit_stat = (paddr_in == RA_STATUS);
   wire logic hit_tplo = (paddr_in == RA_TPLO);
   wire logic hit_tphi = (paddr_in == RA_TPHI);
   wire logic hit_hlat = (paddr_in == RA_THLAT);
   wire logic hit_st   = (paddr_in == RA_STATE);
   wire logic mapped   = hit_acc | hit_stat | hit_tplo | hit_tphi |
                         hit_hlat | hit_st;
   wire logic sw_acc   = apb_wr & hit_acc;
   wire logic sw_stat  = apb_wr & hit_stat;

   cie_alu u_alu (
      .op_in      (exec_op_in),
      .acc_in     (acc_r),
      .mem_in     (exec_mem_in),
      .imm_in     (exec_imm_in),
      .bit_in     (exec_bit_in),
      .flags_in   (flags_r),
      .res_out    (alu_res),
      .flags_out  (alu_flags),
      .wr_acc_out (alu_wr_acc),
      .wr_mem_out (alu_wr_mem),
      .skip_out   (alu_skip)
   );

   cie_table_ptr #(.AW(AW)) u_tab (
      .clk_in        (clk_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .sw_lo_we_in   (apb_wr & hit_tplo),
      .sw_hi_we_in   (apb_wr & hit_tphi),
      .sw_data_in    (pwdata_in[DW-1:0]),
      .bump_in       (tab_go & is_bump(exec_op_in)),
      .final_in      ((exec_op_in == OP_TAB_FINAL) ||
                      (exec_op_in == OP_BTAB_FINAL)),
      .latch_in      (word_in),
      .latch_data_in (pm_data_in[PW-1:PW-DW]),
      .lo_out        (tp_lo),
      .hi_out        (tp_hi),
      .hlat_out      (tp_hlat),
      .addr_out      (tp_addr)
   );

   // sequencer next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (tab_go)
               state_nxt = ST_FETCH;
            else if (alu_go & alu_skip)
               state_nxt = ST_DUMMY;
         ST_FETCH:
            if (pm_valid_in)
               state_nxt = ST_IDLE;
         ST_DUMMY:
            state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   // register read mux
   always_comb
   begin
      prdata_nxt = '0;
      case (1'b1)
         hit_acc:  prdata_nxt[DW-1:0] = acc_r;
         hit_stat: prdata_nxt[FL_W-1:0] = flags_r;
         hit_tplo: prdata_nxt[DW-1:0] = tp_lo;
         hit_tphi: prdata_nxt[AW-DW-1:0] = tp_hi;
         hit_hlat: prdata_nxt[DW-1:0] = tp_hlat;
         hit_st:   prdata_nxt[2:0] = state_r;
         default:  prdata_nxt = '0;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         state_r <= ST_IDLE;
      else if (ce_in)
         state_r <= state_nxt;
   end

   // accumulator and flags; an executing instruction beats software
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         acc_r   <= ACC_RST;
         flags_r <= FLAGS_RST;
      end
      else if (ce_in)
      begin
         if (alu_go & alu_wr_acc)
            acc_r <= alu_res;
         else if (sw_acc)
            acc_r <= pwdata_in[DW-1:0];
         if (alu_go)
            flags_r <= alu_flags;
         else if (sw_stat)
            flags_r <= pwdata_in[FL_W-1:0];
      end
   end

   // data memory write; full address passes through so any section
   // is reached by the extended forms
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         mem_we_out    <= 1'b0;
         mem_addr_out  <= '0;
         mem_wdata_out <= '0;
      end
      else if (ce_in)
      begin
         mem_we_out <= (alu_go & alu_wr_mem) | word_in;
         if (issue)
            mem_addr_out <= exec_addr_in;
         if (alu_go)
            mem_wdata_out <= alu_res;
         else if (word_in)
            mem_wdata_out <= pm_data_in[DW-1:0];
      end
   end

   // program memory request held until the word arrives
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pm_req_out  <= 1'b0;
         pm_addr_out <= '0;
      end
      else if (ce_in)
      begin
         if (tab_go)
         begin
            pm_req_out  <= 1'b1;
            pm_addr_out <= tp_addr;
         end
         else if (word_in)
            pm_req_out <= 1'b0;
      end
   end

   // completion strobes
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         done_out <= 1'b0;
         skip_out <= 1'b0;
         busy_out <= 1'b0;
      end
      else if (ce_in)
      begin
         done_out <= (alu_go & !alu_skip) | word_in |
                     (state_r == ST_DUMMY);
         skip_out <= (state_r == ST_DUMMY);
         busy_out <= (state_nxt != ST_IDLE);
      end
   end

   // apb answer: one wait state, error on unmapped address
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= '0;
      end
      else if (ce_in)
      begin
         pready_out  <= psel_in & penable_in & !pready_out;
         pslverr_out <= psel_in & penable_in & !pready_out & !mapped;
         prdata_out  <= prdata_nxt;
      end
   end

   assign acc_out   = acc_r;
   assign flags_out = flags_r;

endmodule : cie_core_exec

// ### hdl/cie_pkg.sv
// shared constants and types of the instruction execution datapath
package cie_pkg;

   localparam int DW = 8;  // data byte width
   localparam int PW = 16; // program word width
   localparam int PA = 16; // program address width

   // operation codes presented on the execute port
   typedef enum logic [4:0] {
      OP_NOP         = 5'h00,
      OP_SKIP_ZERO   = 5'h01, // skip_when_byte_zero
      OP_SKIP_ZCOPY  = 5'h02, // skip_zero_copy_to_acc
      OP_SKIP_BIT0   = 5'h03, // skip when selected bit clear
      OP_TAB_PAGED   = 5'h04, // table_read_paged
      OP_TAB_FINAL   = 5'h05, // table_read_final_page
      OP_BTAB_PAGED  = 5'h06, // bump_then_table_read_paged
      OP_BTAB_FINAL  = 5'h07, // bump_then_table_read_final
      OP_XOR_ACC     = 5'h08,
      OP_XOR_MEM     = 5'h09, // exclusive_or_into_memory
      OP_XOR_IMM     = 5'h0a,
      OP_ADC         = 5'h0b, // ext_add_carry
      OP_ADCM        = 5'h0c, // ext_add_carry_to_memory
      OP_ADD         = 5'h0d, // ext_add
      OP_ADDM        = 5'h0e, // ext_add_to_memory
      OP_AND         = 5'h0f, // ext_and_to_acc
      OP_ANDM        = 5'h10, // ext_and_to_memory
      OP_CLR         = 5'h11, // ext_clear
      OP_CLR_BIT     = 5'h12, // ext_clear, single bit
      OP_CPL         = 5'h13, // ext_complement
      OP_CPLA        = 5'h14, // ext_complement_to_acc
      OP_DAA_MEM     = 5'h15, // decimal_adjust_to_memory
      OP_DEC         = 5'h16, // ext_decrement
      OP_DECA        = 5'h17, // ext_decrement_to_acc
      OP_INC         = 5'h18, // ext_increment
      OP_INCA        = 5'h19, // ext_increment_to_acc
      OP_MOV_TO_ACC  = 5'h1a, // ext_move, memory to acc
      OP_MOV_TO_MEM  = 5'h1b, // ext_move, acc to memory
      OP_OR          = 5'h1c, // ext_bitwise_or
      OP_ORM         = 5'h1d  // ext_or_to_memory
   } cie_op_t;

   // flag positions in the status byte
   localparam int FL_C  = 0; // carry
   localparam int FL_AC = 1; // half_carry_flag
   localparam int FL_Z  = 2; // zero
   localparam int FL_OV = 3; // twos_complement_wrap_flag
   localparam int FL_SC = 4; // signed_carry_flag
   localparam int FL_W  = 5;

   localparam logic [3:0]    BCD_MAX  = 4'h9;
   localparam logic [3:0]    BCD_ADJ  = 4'h6;
   localparam logic [3:0]    NIB_ZERO = 4'h0;
   localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DW-1:0] BYTE_ONE  = 8'h01;

   // register map, byte addresses
   localparam logic [7:0] RA_ACC    = 8'h00;
   localparam logic [7:0] RA_STATUS = 8'h04;
   localparam logic [7:0] RA_TPLO   = 8'h08;
   localparam logic [7:0] RA_TPHI   = 8'h0c;
   localparam logic [7:0] RA_THLAT  = 8'h10;
   localparam logic [7:0] RA_STATE  = 8'h14;

   localparam logic [FL_W-1:0] FLAGS_RST = 5'h00;
   localparam logic [DW-1:0]   ACC_RST   = 8'h00;

   // sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_FETCH = 3'b010,
      ST_DUMMY = 3'b100
   } cie_state_t;

endpackage : cie_pkg

// ### hdl/cie_alu.sv
// combinational arithmetic and logic unit of the datapath
module cie_alu
   import cie_pkg::*;
(
   input  wire cie_op_t         op_in, // operation
   input  wire logic [DW-1:0]   acc_in, // accumulator
   input  wire logic [DW-1:0]   mem_in, // addressed data byte
   input  wire logic [DW-1:0]   imm_in, // immediate
   input  wire logic [2:0]      bit_in, // bit select
   input  wire logic [FL_W-1:0] flags_in, // current flags
   output logic [DW-1:0]        res_out, // result byte
   output logic [FL_W-1:0]      flags_out, // next flags
   output logic                 wr_acc_out, // result to acc
   output logic                 wr_mem_out, // result to memory
   output logic                 skip_out // skip next instruction
);

   // carry input only for the add-with-carry pair
   wire logic          use_c  = (op_in == OP_ADC) || (op_in == OP_ADCM);
   wire logic          cin    = use_c & flags_in[FL_C];
   wire logic [4:0]    sum_lo = {1'b0, acc_in[3:0]} + {1'b0, mem_in[3:0]}
                                + {4'h0, cin};
   wire logic [7:0]    sum_l7 = {1'b0, acc_in[6:0]} + {1'b0, mem_in[6:0]}
                                + {7'h0, cin};
   wire logic [DW:0]   sum    = {1'b0, acc_in} + {1'b0, mem_in}
                                + {8'h00, cin};
   wire logic          ovf    = sum_l7[7] ^ sum[DW];

   // decimal adjust terms come from the accumulator and old flags
   wire logic          lo_adj = (acc_in[3:0] > BCD_MAX) | flags_in[FL_AC];
   wire logic          hi_adj = (acc_in[7:4] > BCD_MAX) | flags_in[FL_C];
   wire logic [DW:0]   daa    = {1'b0, acc_in}
                                + {1'b0, hi_adj ? BCD_ADJ : NIB_ZERO,
                                   lo_adj ? BCD_ADJ : NIB_ZERO};

   // one-hot mask of the selected bit
   logic [DW-1:0] sel_mask;
   genvar gi;
   generate
      for (gi = 0; gi < DW; gi++)
      begin : g_mask
         assign sel_mask[gi] = (bit_in == 3'(gi));
      end
   endgenerate
   wire logic bit_clear = ~|(mem_in & sel_mask);

   logic upd_z;

   // operation select; zero flag follows the stored byte
   always_comb
   begin
      res_out    = mem_in;
      flags_out  = flags_in;
      wr_acc_out = 1'b0;
      wr_mem_out = 1'b0;
      skip_out   = 1'b0;
      upd_z      = 1'b0;
      case (op_in)
         OP_SKIP_ZERO:
         begin
            wr_mem_out = 1'b1;
            skip_out   = (mem_in == BYTE_ZERO);
         end
         OP_SKIP_ZCOPY:
         begin
            wr_acc_out = 1'b1;
            skip_out   = (mem_in == BYTE_ZERO);
         end
         OP_SKIP_BIT0:  skip_out = bit_clear;
         OP_XOR_ACC, OP_XOR_MEM:
         begin
            res_out    = acc_in ^ mem_in;
            wr_acc_out = (op_in == OP_XOR_ACC);
            wr_mem_out = (op_in == OP_XOR_MEM);
            upd_z      = 1'b1;
         end
         OP_XOR_IMM:
         begin
            res_out    = acc_in ^ imm_in;
            wr_acc_out = 1'b1;
            upd_z      = 1'b1;
         end
         OP_ADC, OP_ADCM, OP_ADD, OP_ADDM:
         begin
            res_out          = sum[DW-1:0];
            wr_acc_out       = (op_in == OP_ADC) || (op_in == OP_ADD);
            wr_mem_out       = !wr_acc_out;
            flags_out[FL_C]  = sum[DW];
            flags_out[FL_AC] = sum_lo[4];
            flags_out[FL_OV] = ovf;
            flags_out[FL_SC] = ovf ^ sum[DW-1];
            upd_z            = 1'b1;
         end
         OP_AND, OP_ANDM:
         begin
            res_out    = acc_in & mem_in;
            wr_acc_out = (op_in == OP_AND);
            wr_mem_out = (op_in == OP_ANDM);
            upd_z      = 1'b1;
         end
         OP_OR, OP_ORM:
         begin
            res_out    = acc_in | mem_in;
            wr_acc_out = (op_in == OP_OR);
            wr_mem_out = (op_in == OP_ORM);
            upd_z      = 1'b1;
         end
         OP_CLR:
         begin
            res_out    = BYTE_ZERO;
            wr_mem_out = 1'b1;
         end
         OP_CLR_BIT:
         begin
            res_out    = mem_in & ~sel_mask;
            wr_mem_out = 1'b1;
         end
         OP_CPL, OP_CPLA:
         begin
            res_out    = ~mem_in;
            wr_acc_out = (op_in == OP_CPLA);
            wr_mem_out = (op_in == OP_CPL);
            upd_z      = 1'b1;
         end
         OP_DAA_MEM:
         begin
            res_out         = daa[DW-1:0];
            wr_mem_out      = 1'b1;
            // carry only, set when the decimal sum passed 99
            flags_out[FL_C] = flags_in[FL_C] | hi_adj | daa[DW];
         end
         OP_DEC, OP_DECA:
         begin
            res_out    = mem_in - BYTE_ONE;
            wr_acc_out = (op_in == OP_DECA);
            wr_mem_out = (op_in == OP_DEC);
            upd_z      = 1'b1;
         end
         OP_INC, OP_INCA:
         begin
            res_out    = mem_in + BYTE_ONE;
            wr_acc_out = (op_in == OP_INCA);
            wr_mem_out = (op_in == OP_INC);
            upd_z      = 1'b1;
         end
         OP_MOV_TO_ACC:  wr_acc_out = 1'b1;
         OP_MOV_TO_MEM:
         begin
            res_out    = acc_in;
            wr_mem_out = 1'b1;
         end
         default: ;
      endcase
      if (upd_z)
         flags_out[FL_Z] = (res_out == BYTE_ZERO);
   end

endmodule : cie_alu

// ### hdl/cie_table_ptr.sv
// table pointer pair, high latch and program address forming
module cie_table_ptr
   import cie_pkg::*;
#(
   parameter int AW = PA // program address width
)(
   input  wire logic          clk_in, // core clock
   input  wire logic          rst_in, // sync reset, high
   input  wire logic          ce_in, // clock enable
   input  wire logic          sw_lo_we_in, // software writes low
   input  wire logic          sw_hi_we_in, // software writes high
   input  wire logic [DW-1:0] sw_data_in, // software data
   input  wire logic          bump_in, // increment low byte
   input  wire logic          final_in, // last page select
   input  wire logic          latch_in, // load high latch
   input  wire logic [DW-1:0] latch_data_in, // word high byte
   output logic [DW-1:0]      lo_out, // table_pointer_low
   output logic [AW-DW-1:0]   hi_out, // table_pointer_high
   output logic [DW-1:0]      hlat_out, // table_high_latch
   output logic [AW-1:0]      addr_out // word address to read
);

   // the increment is seen by the same read that requests it
   wire logic [DW-1:0] lo_nxt = bump_in ? lo_out + BYTE_ONE : lo_out;
   wire logic [AW-DW-1:0] page_sel =
      final_in ? {(AW-DW){1'b1}} : hi_out;

   assign addr_out = {page_sel, lo_nxt};

   // hardware update beats a software write in the same cycle
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         lo_out   <= '0;
         hi_out   <= '0;
         hlat_out <= '0;
      end
      else if (ce_in)
      begin
         if (bump_in)
            lo_out <= lo_nxt;
         else if (sw_lo_we_in)
            lo_out <= sw_data_in;
         if (sw_hi_we_in)
            hi_out <= (AW-DW)'(sw_data_in);
         if (latch_in)
            hlat_out <= latch_data_in;
      end
   end

endmodule : cie_table_ptr

// ### test/cie_core_exec_assertions.sv
// port-level assertions for the instruction execution datapath
module cie_core_exec_assertions
   import cie_pkg::*;
(
   input wire logic         clk_in, rst_in, ce_in, exec_valid_in, busy_out,
   input wire logic         done_out, skip_out, mem_we_out, pm_req_out,
   input wire logic         pm_valid_in,
   input wire cie_op_t      exec_op_in,
   input wire logic [15:0]  exec_addr_in, mem_addr_out, pm_data_in,
   input wire logic [7:0]   exec_mem_in, mem_wdata_out, acc_out,
   input wire logic [4:0]   flags_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // an issue counts only while idle and enabled
   wire tk = exec_valid_in && ce_in && !busy_out;
   property p_zskip;
      tk && exec_op_in == OP_SKIP_ZERO && exec_mem_in == 8'h00
         |=> busy_out && !done_out ##1 done_out && skip_out;
   endproperty
   a_zskip: assert property (p_zskip) else $error("skip timing");
   property p_nzskip;
      tk && exec_op_in == OP_SKIP_ZERO && exec_mem_in != 8'h00
         |=> done_out && !skip_out && mem_wdata_out == $past(exec_mem_in);
   endproperty
   a_nzskip: assert property (p_nzskip) else $error("no skip");
   property p_copy;
      tk && exec_op_in == OP_SKIP_ZCOPY
         |=> acc_out == $past(exec_mem_in) && $stable(flags_out);
   endproperty
   a_copy: assert property (p_copy) else $error("copy skip");
   property p_clr;
      tk && exec_op_in == OP_CLR |=> mem_we_out && mem_wdata_out == 8'h00;
   endproperty
   a_clr: assert property (p_clr) else $error("clear");
   property p_cpla;
      tk && exec_op_in == OP_CPLA |=> acc_out == ~$past(exec_mem_in)
         && !mem_we_out && flags_out[FL_Z] == (acc_out == 8'h00);
   endproperty
   a_cpla: assert property (p_cpla) else $error("complement");
   property p_inc;
      tk && exec_op_in == OP_INC |=> mem_wdata_out == $past(exec_mem_in)
         + 8'h01 && mem_addr_out == $past(exec_addr_in);
   endproperty
   a_inc: assert property (p_inc) else $error("increment");
   property p_mov;
      tk && exec_op_in == OP_MOV_TO_MEM
         |=> mem_wdata_out == $past(acc_out) && $stable(flags_out);
   endproperty
   a_mov: assert property (p_mov) else $error("move");
   property p_tab;
      pm_req_out && pm_valid_in && ce_in
         |=> done_out && mem_wdata_out == $past(pm_data_in[7:0]);
   endproperty
   a_tab: assert property (p_tab) else $error("table word");
   c_daa: cover property (tk && exec_op_in == OP_DAA_MEM);
   c_skip: cover property (done_out && skip_out);
   c_tab: cover property (pm_req_out && pm_valid_in);
endmodule : cie_core_exec_assertions
bind cie_core_exec cie_core_exec_assertions u_chk (.*);

// ### test/cie_pm_model.sv
// program memory answering table fetches after a chosen delay
module cie_pm_model
(
   input wire logic        clk_in, rst_in, req_in,
   input wire logic [15:0] addr_in,
   input wire logic [1:0]  lat_in,
   output logic            valid_out,
   output logic [15:0]     data_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_r;
   // word derived from its address; bus toggles outside the answer
   always_ff @(posedge clk_in)
   begin
      valid_out <= req_in && !valid_out && !rst_in && wait_r == lat_in;
      wait_r    <= (req_in && !valid_out) ? wait_r + 2'h1 : 2'h0;
      data_out  <= rst_in ? 16'h0000 : (req_in && wait_r == lat_in)
         ? {addr_in[7:0] ^ addr_in[15:8], ~addr_in[7:0]} : ~data_out;
   end
endmodule : cie_pm_model

// ### test/cie_core_exec_tb.sv
// self-checking bench for the instruction execution datapath
module cie_core_exec_tb
   import cie_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 0, rst_in = 1, ce_in = 1, psel_in = 0, penable_in = 0;
   logic pwrite_in = 0, exec_valid_in = 0, pready_out, pslverr_out, busy_out;
   logic done_out, skip_out, mem_we_out, pm_req_out, pm_valid_in, c1, wm, wa;
   logic [7:0]  paddr_in = 8'h00, exec_mem_in = 8'h00, exec_imm_in = 8'h00;
   logic [7:0]  mem_wdata_out, acc_out, tlo, thi, hl, a, r, d, m;
   logic [31:0] pwdata_in = 32'h0, prdata_out, v;
   logic [15:0] exec_addr_in = 16'h0, mem_addr_out, pm_addr_out, pm_data_in;
   logic [15:0] w;
   logic [2:0]  exec_bit_in = 3'h0;
   logic [1:0]  lat = 2'h0;
   logic [4:0]  flags_out, f;
   logic [8:0]  s;
   cie_op_t     exec_op_in = OP_NOP;
   int          fails = 0, n_checks = 0;
   always #5 clk_in = ~clk_in;
   cie_core_exec u_dut (.*);
   cie_pm_model u_pm (.clk_in(clk_in), .rst_in(rst_in), .req_in(pm_req_out),
      .addr_in(pm_addr_out), .lat_in(lat), .valid_out(pm_valid_in),
      .data_out(pm_data_in));
   task automatic chk(input string nm, input logic [23:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [7:0] ad, input [31:0] dt);
      @(posedge clk_in);
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, wr, ad, dt};
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      v = prdata_out;
      c1 = pslverr_out;
      {psel_in, penable_in} <= 2'b00;
   endtask : apb
   // issue one operation, compare with the bench model
   task automatic ex(input cie_op_t o);
      m = ($urandom_range(3) == 0) ? 8'h00 : 8'($urandom);
      w = 16'($urandom);
      @(posedge clk_in);
      {exec_valid_in, exec_op_in, exec_mem_in, exec_addr_in} <= {1'b1, o, m, w};
      {exec_imm_in, exec_bit_in, lat} <= 13'($urandom);
      @(posedge clk_in);
      exec_valid_in <= 1'b0;
      do @(posedge clk_in); while (done_out !== 1'b1);
      tlo += 8'(o inside {OP_BTAB_PAGED, OP_BTAB_FINAL});
      w = (o inside {OP_TAB_FINAL, OP_BTAB_FINAL}) ? {8'hff, tlo} : {thi, tlo};
      w = {w[7:0] ^ w[15:8], ~w[7:0]};
      c1 = (o inside {OP_ADC, OP_ADCM}) & f[FL_C];
      s = a + m + c1;
      d = {(a[7:4] > 9 || f[FL_C]) ? 4'h6 : 4'h0, (a[3:0] > 9 || f[FL_AC]) ? 4'h6 : 4'h0};
      case (o)
         OP_SKIP_ZERO, OP_SKIP_ZCOPY, OP_MOV_TO_ACC: r = m;
         OP_XOR_ACC, OP_XOR_MEM: r = a ^ m;
         OP_XOR_IMM: r = a ^ exec_imm_in;
         OP_ADC, OP_ADCM, OP_ADD, OP_ADDM: r = s[7:0];
         OP_AND, OP_ANDM: r = a & m;
         OP_OR, OP_ORM: r = a | m;
         OP_CLR: r = 8'h00;
         OP_CLR_BIT: r = m & ~(8'h01 << exec_bit_in);
         OP_CPL, OP_CPLA: r = ~m;
         OP_DAA_MEM: r = a + d;
         OP_DEC, OP_DECA: r = m - 8'h01;
         OP_INC, OP_INCA: r = m + 8'h01;
         OP_MOV_TO_MEM: r = a;
         default: r = w[7:0];
      endcase
      wa = o inside {OP_SKIP_ZCOPY, OP_XOR_ACC, OP_XOR_IMM, OP_ADC, OP_ADD,
         OP_AND, OP_CPLA, OP_DECA, OP_INCA, OP_MOV_TO_ACC, OP_OR};
      wm = o > OP_SKIP_BIT0 && !wa;
      if (o inside {[OP_ADC:OP_ADDM]})
      begin
         f[FL_OV] = a[7] == m[7] && r[7] != a[7];
         f[2:0] = {r == 8'h00, 5'(a[3:0]) + m[3:0] + c1 > 5'h0f, s[8]};
         f[FL_SC] = f[FL_OV] ^ r[7];
      end
      if (o inside {[OP_XOR_ACC:OP_XOR_IMM], [OP_AND:OP_ANDM], OP_CPL,
         OP_CPLA, [OP_DEC:OP_INCA], [OP_OR:OP_ORM]})
         f[FL_Z] = r == 8'h00;
      if (o == OP_DAA_MEM)
         f[FL_C] = f[FL_C] || d[5] || 9'(a) + d > 9'h0ff;
      if (wa)
         a = r;
      if (o > OP_SKIP_BIT0)
         chk("mem_we", wm, mem_we_out);
      if (wm)
         chk("mem_data", {exec_addr_in, r}, {mem_addr_out, mem_wdata_out});
      chk("skip", o inside {OP_SKIP_ZERO, OP_SKIP_ZCOPY} ? m == 8'h00 : o == OP_SKIP_BIT0 && !m[exec_bit_in], skip_out);
      chk("acc_flags", {a, 3'h0, f}, {acc_out, 3'h0, flags_out});
      if (o inside {[OP_TAB_PAGED:OP_BTAB_FINAL]})
      begin
         apb(1'b0, RA_THLAT, 32'h0);
         chk("latch", w[15:8], v[15:0]);
      end
   endtask : ex
   // watchdog: the sweep needs about 1800 cycles
   initial
   begin
      #100000;
      fails++;
      conclude();
   end
   initial
   begin
      void'($urandom(1));
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      apb(1'b0, RA_STATE, 32'h0);
      chk("state", 16'(ST_IDLE), v[15:0]);
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped", 16'h0100, {7'h0, c1, v[7:0]});
      $display("test register access done");
      for (int k = 0; k < 87; k++)
      begin
         {thi, tlo, f, a} = 29'($urandom);
         apb(1'b1, RA_ACC, {24'h0, a});
         apb(1'b1, RA_STATUS, {27'h0, f});
         apb(1'b1, RA_TPLO, {24'h0, tlo});
         apb(1'b1, RA_TPHI, {24'h0, thi});
         ex(cie_op_t'(k % 29 + 1));
      end
      $display("test operation sweep done");
      conclude();
   end
endmodule : cie_core_exec_tb
